// ==== hw/vt_vertical.sv ====
`timescale 1ns/1ps
// Behaviour
// - Vertical total is ten bits, overflow bits 0,5
// - Display end is ten bits, overflow bits 1,6
// - Sync start is ten bits, overflow bits 2,7
// - Sync begins on line equal sync start
// - Blank start from overflow bit 3, maxscan bit 5
// - Blanking begins on line equal blank start
// - Line compare assembled; address restarts at zero there
// - Split screen: lower part shows buffer start
// - Overflow bit 4 stays writable under protection
// - Protected indexes zero to seven ignore writes
// - Byte pan shifts 9 or 8 pixel steps
// - Nine dot disable forces 8 pixel steps
// - Preset register bit 7 reads zero
module vt_vertical (
  // Clock and reset.
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // Indexed register port.
  input  wire logic               idx_wr,
  input  wire logic               data_wr,
  input  wire logic [7:0]         wdata,
  output logic      [7:0]         rdata,
  // Line and mode inputs.
  input  wire logic               line_tick,
  input  wire logic               text_9dot,
  input  wire logic               nine_dot_disable,
  // Timing outputs.
  output vt_pkg::vt_timing_s      timing,
  output logic      [10:0]        scan_line,
  output logic      [4:0]         row_scan,
  output logic      [15:0]        mem_base,
  output logic      [4:0]         byte_pan_px,
  output logic                    write_protect
);
  import vt_pkg::*;

  vt_state_s  s;
  vt_state_s  next_s;
  logic [9:0] vtot;
  logic [9:0] vdee;
  logic [9:0] vss10;
  logic [9:0] vbs10;
  logic [9:0] lc10;
  logic       prot;
  logic       wrap;
  logic [10:0] nl;

  // Assemble the ten bit values from low bytes and overflow bits.
  assign vtot  = {s.ovf[OVF_VT9], s.ovf[OVF_VT8], s.vtotal};
  assign vdee  = {s.ovf[OVF_VDE9], s.ovf[OVF_VDE8], s.vde};
  assign vss10 = {s.ovf[OVF_VSS9], s.ovf[OVF_VSS8], s.vss};
  assign vbs10 = {s.maxscan[MSL_VBS9], s.ovf[OVF_VBS8], s.vbs};
  assign lc10  = {s.maxscan[MSL_LC9], s.ovf[OVF_LC8], s.lcmp};
  assign prot  = s.vse[VSE_WP];
  // The frame holds vtot plus two lines, so the last is vtot plus one.
  assign wrap  = (s.line == ({1'b0, vtot} + 11'h001));
  assign nl    = wrap ? RST_LINE : s.line + 11'h001;

  // Register writes, line counting and read data.
  always_comb begin
    next_s = s;
    if (idx_wr) begin
      next_s.idx = wdata[6:0];
    end
    if (data_wr && !(prot && s.idx <= IDX_WP_LAST)) begin
      case (s.idx)
        IDX_VTOTAL:  next_s.vtotal  = wdata;
        IDX_OVF:     next_s.ovf     = wdata;
        IDX_PRESET:  next_s.preset  = wdata;
        IDX_MAXSCAN: next_s.maxscan = wdata;
        IDX_SAH:     next_s.sah     = wdata;
        IDX_SAL:     next_s.sal     = wdata;
        IDX_VSS:     next_s.vss     = wdata;
        IDX_VSE:     next_s.vse     = wdata;
        IDX_VDE:     next_s.vde     = wdata;
        IDX_VBS:     next_s.vbs     = wdata;
        IDX_LCMP:    next_s.lcmp    = wdata;
        // Unmapped indexes drop the data but keep any new index.
        default: begin
        end
      endcase
    end
    // Line compare bit 8 escapes protection on the overflow register.
    if (data_wr && prot && s.idx == IDX_OVF) begin
      next_s.ovf = (s.ovf & ~OVF_WP_FREE) | (wdata & OVF_WP_FREE);
    end
    // Line, timing and row scan move only at a line boundary; read data does not.
    if (line_tick) begin
      next_s.line = nl;
      next_s.tim.vde = ({1'b0, nl} <= {2'b00, vdee});
      if (nl == {1'b0, vss10}) begin
        next_s.tim.vsync = 1'b1;
      end else if (nl[3:0] == s.vse[3:0]) begin
        next_s.tim.vsync = 1'b0;
      end
      if (wrap) begin
        next_s.tim.vblank = 1'b0;
      end else if (nl == {1'b0, vbs10}) begin
        next_s.tim.vblank = 1'b1;
      end
      // Row scan: preset at frame top, zero at the split line.
      if (wrap) begin
        next_s.row = s.preset[4:0];
        next_s.tim.split = 1'b0;
      end else if (nl == {1'b0, lc10}) begin
        next_s.row = 5'h00;
        next_s.tim.split = 1'b1;
      end else if (s.row == s.maxscan[4:0]) begin
        next_s.row = 5'h00;
      end else begin
        next_s.row = s.row + 5'h01;
      end
    end
    // Read data is registered, so it follows the index by a cycle.
    case (s.idx)
      IDX_VTOTAL:  next_s.rdata = s.vtotal;
      IDX_OVF:     next_s.rdata = s.ovf;
      IDX_PRESET:  next_s.rdata = {1'b0, s.preset[6:0]};
      IDX_MAXSCAN: next_s.rdata = s.maxscan;
      IDX_SAH:     next_s.rdata = s.sah;
      IDX_SAL:     next_s.rdata = s.sal;
      IDX_VSS:     next_s.rdata = s.vss;
      IDX_VSE:     next_s.rdata = s.vse;
      IDX_VDE:     next_s.rdata = s.vde;
      IDX_VBS:     next_s.rdata = s.vbs;
      IDX_LCMP:    next_s.rdata = s.lcmp;
      default:     next_s.rdata = RST_REG;
    endcase
  end

  // State register; all registers clear to zero on reset.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Byte pan: 9 pixel steps only for 9-dot text without the override.
  always_comb begin
    if (text_9dot && !nine_dot_disable) begin
      byte_pan_px = 5'(s.preset[6:5] * PAN_STEP9);
    end else begin
      byte_pan_px = 5'(s.preset[6:5] * PAN_STEP8);
    end
  end

  // Upper part fetches from the start address, lower from byte zero.
  assign mem_base      = s.tim.split ? 16'h0000 : {s.sah, s.sal};
  assign rdata         = s.rdata;
  assign timing        = s.tim;
  assign scan_line     = s.line;
  assign row_scan      = s.row;
  assign write_protect = prot;

  // Checks on the logic above.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_total_wrap: assert property (
    line_tick && s.line == {1'b0, vtot} + 11'h001 |=> s.line == 11'h000)
    else $error("line counter did not wrap after total plus two");
  a_line_step: assert property (
    line_tick && !wrap |=> s.line == $past(s.line) + 11'h001)
    else $error("line counter did not advance");
  a_line_hold: assert property (
    !line_tick |=> $stable(s.line))
    else $error("line counter moved without a line tick");
  a_vsync_start: assert property (
    line_tick && nl == {1'b0, vss10} |=> timing.vsync)
    else $error("sync did not start on its line");
  a_vblank_start: assert property (
    line_tick && !wrap && nl == {1'b0, vbs10} |=> timing.vblank)
    else $error("blanking did not start on its line");
  a_vde_end: assert property (
    timing.vde |-> {1'b0, scan_line} <= {2'b00, vdee})
    else $error("display enable beyond its end line");
  a_split_base: assert property (
    line_tick && !wrap && nl == {1'b0, lc10}
    |=> timing.split && mem_base == 16'h0000 && row_scan == 5'h00)
    else $error("line compare did not restart the address");
  a_wp_block: assert property (
    data_wr && prot && s.idx < IDX_OVF |=> $stable(s.vtotal))
    else $error("protected register changed");
  a_ovf_bit4: assert property (
    data_wr && prot && s.idx == IDX_OVF
    |=> s.ovf[OVF_LC8] == $past(wdata[OVF_LC8])
        && s.ovf[7:5] == $past(s.ovf[7:5]))
    else $error("overflow protection wrong");
  a_preset_read: assert property (
    s.idx == IDX_PRESET && !idx_wr |=> rdata[PRS_RSV] == 1'b0)
    else $error("preset bit 7 read as one");
  a_pan_steps: assert property (
    nine_dot_disable |-> byte_pan_px == 5'(s.preset[6:5] * PAN_STEP8))
    else $error("nine dot disable did not force 8 pixel steps");
  a_row_preset: assert property (
    line_tick && wrap |=> row_scan == $past(s.preset[4:0]))
    else $error("row scan not preset at frame top");

  c_frame_wrap: cover property (line_tick && wrap);
  c_split: cover property (line_tick && !wrap && nl == {1'b0, lc10});
  c_vsync: cover property ($rose(timing.vsync));
  c_wp_write: cover property (data_wr && prot && s.idx == IDX_OVF);

endmodule

// ==== inc/vt_pkg.sv ====
package vt_pkg;

  // Register indexes behind the indexed data port.
  localparam logic [6:0] IDX_VTOTAL  = 7'h06;
  localparam logic [6:0] IDX_OVF     = 7'h07;
  localparam logic [6:0] IDX_PRESET  = 7'h08;
  localparam logic [6:0] IDX_MAXSCAN = 7'h09;
  localparam logic [6:0] IDX_SAH     = 7'h0C;
  localparam logic [6:0] IDX_SAL     = 7'h0D;
  localparam logic [6:0] IDX_VSS     = 7'h10;
  localparam logic [6:0] IDX_VSE     = 7'h11;
  localparam logic [6:0] IDX_VDE     = 7'h12;
  localparam logic [6:0] IDX_VBS     = 7'h15;
  localparam logic [6:0] IDX_LCMP    = 7'h18;
  // Highest index of the write protected timing group.
  localparam logic [6:0] IDX_WP_LAST = 7'h07;

  // Field positions.
  localparam int OVF_VT8   = 0;
  localparam int OVF_VDE8  = 1;
  localparam int OVF_VSS8  = 2;
  localparam int OVF_VBS8  = 3;
  localparam int OVF_LC8   = 4;
  localparam int OVF_VT9   = 5;
  localparam int OVF_VDE9  = 6;
  localparam int OVF_VSS9  = 7;
  localparam int MSL_VBS9  = 5;
  localparam int MSL_LC9   = 6;
  localparam int VSE_WP    = 7;
  localparam int PRS_RSV   = 7;
  // Overflow bits that stay writable under protection.
  localparam logic [7:0] OVF_WP_FREE = 8'h10;
  // Pixel steps of the byte pan field.
  localparam logic [4:0] PAN_STEP9 = 5'h09;
  localparam logic [4:0] PAN_STEP8 = 5'h08;

  // Reset values.
  localparam logic [7:0] RST_REG  = 8'h00;
  localparam logic [10:0] RST_LINE = 11'h000;

  // Vertical timing outputs travelling together.
  typedef struct packed {
    logic vde;
    logic vblank;
    logic vsync;
    logic split;
  } vt_timing_s;

  // Whole state of the block.
  typedef struct packed {
    logic [6:0]  idx;
    logic [7:0]  vtotal;
    logic [7:0]  ovf;
    logic [7:0]  preset;
    logic [7:0]  maxscan;
    logic [7:0]  sah;
    logic [7:0]  sal;
    logic [7:0]  vss;
    logic [7:0]  vse;
    logic [7:0]  vde;
    logic [7:0]  vbs;
    logic [7:0]  lcmp;
    logic [10:0] line;
    logic [4:0]  row;
    logic [7:0]  rdata;
    vt_timing_s  tim;
  } vt_state_s;

endpackage

// ==== testbench/test_vt_vertical.sv ====
`timescale 1ns/1ps
module test_vt_vertical;
  import vt_pkg::*;
  // Design inputs and outputs.
  logic        ref_clk, rst, idx_wr, data_wr, line_tick;
  logic        text_9dot, nine_dot_disable, write_protect;
  logic [7:0]  wdata, rdata, vse, mx, pr;
  vt_timing_s  timing;
  logic [10:0] scan_line, l;
  logic [4:0]  row_scan, byte_pan_px, row;
  logic [15:0] mem_base, sa;
  logic [9:0]  vt, de, ss, bs, lc;
  logic        vs, vb, sp;
  logic [6:0]  ix [11];
  logic [7:0]  dv [11];
  int          n_errors, n_compared, cyc;

  vt_vertical i_vt_vertical (.ref_clk(ref_clk), .rst(rst), .idx_wr(idx_wr),
    .data_wr(data_wr), .wdata(wdata), .rdata(rdata), .line_tick(line_tick),
    .text_9dot(text_9dot), .nine_dot_disable(nine_dot_disable),
    .timing(timing), .scan_line(scan_line), .row_scan(row_scan),
    .mem_base(mem_base), .byte_pan_px(byte_pan_px),
    .write_protect(write_protect));

  // The clock toggles every 20 ns, a period of 40 ns.
  always #20 ref_clk = ~ref_clk;

  // A hang in any handshake ends the run as a failure.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 10000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [47:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Index cycle, then data cycle; the register changes at the last edge.
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    @(posedge ref_clk) begin idx_wr <= 1; wdata <= {1'b0, i}; end
    @(posedge ref_clk) begin idx_wr <= 0; data_wr <= 1; wdata <= d; end
    @(posedge ref_clk) data_wr <= 0;
    #1;
  endtask

  // Read data trails the index by one registered cycle.
  task automatic rd(input logic [6:0] i, input logic [7:0] e);
    @(posedge ref_clk) begin idx_wr <= 1; wdata <= {1'b0, i}; end
    @(posedge ref_clk) idx_wr <= 0;
    @(posedge ref_clk);
    #1 chk("rdata", e, rdata);
  endtask

  // One line boundary; the bench steps its own frame model alongside.
  task automatic tick();
    @(posedge ref_clk) line_tick <= 1;
    @(posedge ref_clk) line_tick <= 0;
    #1;
    if (l == vt + 11'd1) begin
      l = 0; vb = 0; sp = 0; row = pr[4:0];
    end else begin
      l = l + 11'd1;
      if (l == lc) begin row = 0; sp = 1; end
      else row = (row == mx[4:0]) ? 5'h00 : row + 5'h01;
    end
    if (l == ss) vs = 1;
    else if (l[3:0] == vse[3:0]) vs = 0;
    if (l == bs) vb = 1;
    chk("frame", {l <= de, vb, vs, sp, l, row, sp ? 16'h0000 : sa},
        {timing, scan_line, row_scan, mem_base});
  endtask

  initial begin
    {ref_clk, rst, idx_wr, data_wr, line_tick} = 5'h08;
    {text_9dot, nine_dot_disable, wdata} = 10'h000;
    {n_errors, n_compared, cyc, l, vs, vb, sp, row} = '0;
    void'($urandom(41));
    repeat (3) @(posedge ref_clk);
    rst <= 0;
    rd(IDX_VTOTAL, 8'h00);
    chk("write_protect", 1'b0, write_protect);
    // Every high bit set except line compare bit 8, so overflow bit 4 stays clear here.
    {vt, de, ss, bs, lc} = {10'h302, 10'h300, 10'h302, 10'h301, 10'h2F0};
    {mx, vse, sa, pr} = {8'h63, 8'h05, 16'($urandom), 8'($urandom)};
    ix = '{IDX_VTOTAL, IDX_OVF, IDX_MAXSCAN, IDX_VSS, IDX_VDE, IDX_VBS,
           IDX_LCMP, IDX_VSE, IDX_SAH, IDX_SAL, IDX_PRESET};
    dv = '{vt[7:0], {ss[9], de[9], vt[9], lc[8], bs[8], ss[8], de[8], vt[8]},
           mx, ss[7:0], de[7:0], bs[7:0], lc[7:0], vse, sa[15:8], sa[7:0], pr};
    for (int i = 0; i < 11; i++) begin
      wr(ix[i], dv[i]);
      rd(ix[i], (ix[i] == IDX_PRESET) ? dv[i] & 8'h7F : dv[i]);
    end
    repeat (1549) tick();
    // Protection on: timing group frozen except overflow bit 4.
    wr(IDX_VSE, 8'h85);
    chk("write_protect", 1'b1, write_protect);
    wr(IDX_VTOTAL, 8'h55);
    rd(IDX_VTOTAL, vt[7:0]);
    wr(IDX_OVF, 8'h10);
    rd(IDX_OVF, dv[1] | 8'h10);
    wr(7'h1F, 8'hA5);
    rd(7'h1F, 8'h00);
    // Preset sits past the protected group, so it still takes writes.
    for (int k = 0; k < 16; k++) begin
      @(posedge ref_clk) {nine_dot_disable, text_9dot} <= k[1:0];
      pr = {1'b1, k[3:2], 5'($urandom)};
      wr(IDX_PRESET, pr);
      chk("byte_pan_px", k[3:2] * ((k[0] && !k[1]) ? 9 : 8), byte_pan_px);
    end
    rd(IDX_PRESET, pr & 8'h7F);
    close_out();
  end
endmodule
